// ===== core/mba_pkg.sv
package mba_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_ANYREQ_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] CODE_HALT = 3'h3;
  localparam logic [2:0] CODE_PASSIVE = 3'h7;
  localparam int CODE_MEM_BIT = 2;

  typedef enum logic [1:0] {MODE_SINGLE, MODE_RESIDENT, MODE_IO, MODE_IO_RESIDENT} mba_mode_t;
  typedef enum logic [1:0] {ARB_IDLE, ARB_REQUEST, ARB_OWNER} mba_arb_state_t;

  // processor-side decisions carried to the bus clock as levels
  typedef struct packed {
    logic wantBus;
    logic haltNow;
    logic commonSurrender;
    logic lockActive;
    logic commonLockout;
    logic anyRequest;
    logic enable;
  } mba_decision_t;
endpackage

// ===== core/mba_arbiter.sv
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Contract
// - decode the three active-low status inputs on the processor clock to classify cycles
// - halt and passive codes request only while lock is low; halt surrenders unless lock is low
// - resident strap high gives resident mode, io strap low gives io mode
// - single mode requests every access; surrenders on halt, idle with common, priority
// - resident mode requests on select high; surrenders on halt, priority, select low or idle with common
// - io mode requests memory accesses; surrenders on halt, priority, io or idle with common
// - io plus resident requests memory with select high; surrenders on halt, priority, io or select low with common
// - lock low keeps requesting and never surrenders a held bus
// - common lockout low ignores every surrender condition that depends on common request
// - any-request high releases as soon as common request goes low
// - priority input high counts as a higher-priority request in every mode
// - arbitration runs on the system bus clock
// - initialize resets arbitration so nobody owns the bus afterwards
// - owner pulls the open-collector busy line low; high means bus free
// - requesting arbiter pulls the open-collector common request line low
module mba_arbiter (
  input wire logic clk,
  input wire logic reset,
  input wire logic busClk,
  input wire logic system_init_n,
  input wire logic status_bit0_n,
  input wire logic status_bit1_n,
  input wire logic status_bit2_n,
  input wire logic lock_n,
  input wire logic common_req_lockout_n,
  input wire logic resident_mode_strap,
  input wire logic io_mode_strap_n,
  input wire logic release_on_any_request,
  input wire logic system_or_local_select,
  input wire logic priority_in_n,
  output logic priority_out_n,
  output logic bus_request_n,
  input wire logic busy_in_n,
  output logic busy_out,
  output logic busy_oe,
  input wire logic common_request_in_n,
  output logic common_request_out,
  output logic common_request_oe,
  output logic address_enable_n,
  input wire logic [mba_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [mba_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int PIN_W = 9;

  // ---------------- processor clock domain ----------------
  logic [PIN_W-1:0] pinMeta;
  logic [PIN_W-1:0] pinSync;
  logic [1:0] ctrl;
  logic ownMeta;
  logic ownSync;
  logic reqMetaC;
  logic reqSyncC;
  mba_pkg::mba_decision_t decision;

  wire [PIN_W-1:0] pinRaw = {status_bit2_n, status_bit1_n, status_bit0_n, lock_n, common_req_lockout_n,
    resident_mode_strap, io_mode_strap_n, release_on_any_request, system_or_local_select};

  always_ff @(posedge clk) begin
    pinMeta <= pinRaw;
    pinSync <= pinMeta;
  end

  wire [2:0] statusCode = pinSync[8:6];
  wire lockLow = ~pinSync[5];
  wire lockoutLow = ~pinSync[4];
  wire residentStrap = pinSync[3];
  wire ioStrapN = pinSync[2];
  wire anyReqPin = pinSync[1];
  wire selectHigh = pinSync[0];

  wire halt_state = (statusCode == mba_pkg::CODE_HALT);
  wire idle_state = (statusCode == mba_pkg::CODE_PASSIVE);
  wire busAccess = ~halt_state & ~idle_state;
  wire memAccess = statusCode[mba_pkg::CODE_MEM_BIT] & ~idle_state;
  wire ioAccess = ~statusCode[mba_pkg::CODE_MEM_BIT] & ~halt_state;

  wire mba_pkg::mba_mode_t mode = ~ioStrapN ? (residentStrap ? mba_pkg::MODE_IO_RESIDENT : mba_pkg::MODE_IO)
    : (residentStrap ? mba_pkg::MODE_RESIDENT : mba_pkg::MODE_SINGLE);

  logic reqCond;
  logic commonCond;
  always_comb begin
    unique case (mode)
      mba_pkg::MODE_SINGLE: begin
        reqCond = busAccess;
        commonCond = idle_state;
      end
      mba_pkg::MODE_RESIDENT: begin
        reqCond = busAccess & selectHigh;
        commonCond = ~selectHigh | idle_state;
      end
      mba_pkg::MODE_IO: begin
        reqCond = memAccess;
        commonCond = ioAccess | idle_state;
      end
      mba_pkg::MODE_IO_RESIDENT: begin
        reqCond = memAccess & selectHigh;
        commonCond = ioAccess | ~selectHigh;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      decision <= '0;
    end else begin
      decision.wantBus <= reqCond | lockLow;
      decision.haltNow <= halt_state;
      decision.commonSurrender <= commonCond;
      decision.lockActive <= lockLow;
      decision.commonLockout <= lockoutLow;
      decision.anyRequest <= anyReqPin | ctrl[mba_pkg::CTRL_ANYREQ_BIT];
      decision.enable <= ctrl[mba_pkg::CTRL_ENABLE_BIT];
    end
  end

  // ownership and request state back from the bus clock
  logic busOwned;
  logic busRequesting;
  always_ff @(posedge clk) begin
    if (reset) begin
      ownMeta <= 1'b0;
      ownSync <= 1'b0;
      reqMetaC <= 1'b0;
      reqSyncC <= 1'b0;
    end else begin
      ownMeta <= busOwned;
      ownSync <= ownMeta;
      reqMetaC <= busRequesting;
      reqSyncC <= reqMetaC;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      address_enable_n <= 1'b1;
    end else begin
      address_enable_n <= ~ownSync;
    end
  end

  // ---------------- register slave ----------------
  logic awHeld;
  logic wHeld;
  logic [mba_pkg::ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;

  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire writeGo = awHeld & wHeld & ~s_axi_bvalid;
  wire writeCtrl = writeGo & (awAddr == mba_pkg::CTRL_OFFSET);
  wire writeKnown = writeCtrl | (awAddr == mba_pkg::STATUS_OFFSET);
  wire arTake = s_axi_arvalid & s_axi_arready;
  wire readCtrl = (s_axi_araddr == mba_pkg::CTRL_OFFSET);
  wire readStatus = (s_axi_araddr == mba_pkg::STATUS_OFFSET);
  wire [31:0] statusWord = {24'h0, statusCode, mode, reqSyncC, ownSync, 1'b0};
  wire [31:0] readWord = readCtrl ? {30'h0, ctrl} : (readStatus ? statusWord : 32'h0);

  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mba_pkg::RESP_OKAY;
      ctrl <= mba_pkg::CTRL_RESET;
    end else begin
      s_axi_awready <= ~awHeld & ~awTake;
      s_axi_wready <= ~wHeld & ~wTake;
      if (awTake) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (writeGo) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= writeKnown ? mba_pkg::RESP_OKAY : mba_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (writeCtrl & wStrb[0]) begin
        ctrl <= wData[1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= mba_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~arTake;
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readWord;
        s_axi_rresp <= (readCtrl | readStatus) ? mba_pkg::RESP_OKAY : mba_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- system bus clock domain ----------------
  logic initMeta;
  logic initSync;
  mba_pkg::mba_decision_t decMeta;
  mba_pkg::mba_decision_t decSync;
  mba_pkg::mba_arb_state_t arbState;
  mba_pkg::mba_arb_state_t next_arbState;

  always_ff @(posedge busClk) begin
    initMeta <= ~system_init_n;
    initSync <= initMeta;
    decMeta <= decision;
    decSync <= decMeta;
  end

  // shared bus wires already run on busClk; a resampled busy would grant a bus just taken
  wire higher_priority_request = priority_in_n;
  wire busFree = busy_in_n;
  wire commonActive = ~common_request_in_n;
  wire commonRelease = commonActive & ~decSync.commonLockout
    & (decSync.commonSurrender | decSync.anyRequest);
  wire surrender = ~decSync.lockActive
    & (decSync.haltNow | higher_priority_request | commonRelease);

  always_comb begin
    next_arbState = arbState;
    unique case (arbState)
      mba_pkg::ARB_IDLE: begin
        if (decSync.wantBus & decSync.enable) begin
          next_arbState = mba_pkg::ARB_REQUEST;
        end
      end
      mba_pkg::ARB_REQUEST: begin
        if (~decSync.wantBus | ~decSync.enable) begin
          next_arbState = mba_pkg::ARB_IDLE;
        end else if (~higher_priority_request & busFree) begin
          next_arbState = mba_pkg::ARB_OWNER;
        end
      end
      mba_pkg::ARB_OWNER: begin
        if (surrender) begin
          next_arbState = mba_pkg::ARB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge busClk) begin
    if (initSync) begin
      arbState <= mba_pkg::ARB_IDLE;
      busOwned <= 1'b0;
      busRequesting <= 1'b0;
      bus_request_n <= 1'b1;
      priority_out_n <= 1'b1;
      busy_out <= 1'b0;
      busy_oe <= 1'b0;
      common_request_out <= 1'b0;
      common_request_oe <= 1'b0;
    end else begin
      arbState <= next_arbState;
      busOwned <= (next_arbState == mba_pkg::ARB_OWNER);
      busRequesting <= (next_arbState == mba_pkg::ARB_REQUEST);
      bus_request_n <= (next_arbState == mba_pkg::ARB_IDLE);
      priority_out_n <= (next_arbState == mba_pkg::ARB_IDLE) & ~higher_priority_request;
      busy_out <= 1'b0;
      busy_oe <= (next_arbState == mba_pkg::ARB_OWNER);
      common_request_out <= 1'b0;
      common_request_oe <= (next_arbState == mba_pkg::ARB_REQUEST);
    end
  end
endmodule // mba_arbiter

// ===== verification/mba_arbiter_props.sv
`timescale 1ns/1ps
module mba_arbiter_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic busClk,
  input wire logic system_init_n,
  input wire logic status_bit0_n,
  input wire logic status_bit1_n,
  input wire logic status_bit2_n,
  input wire logic lock_n,
  input wire logic priority_in_n,
  input wire logic bus_request_n,
  input wire logic busy_out,
  input wire logic busy_oe,
  input wire logic common_request_out,
  input wire logic common_request_oe,
  input wire logic address_enable_n
);
  wire [2:0] statusCode = {status_bit2_n, status_bit1_n, status_bit0_n};
  wire halted = (statusCode == mba_pkg::CODE_HALT) && lock_n;
  sequence locked8;
    (!lock_n)[*8];
  endsequence
  pull_low_a: assert property (@(posedge busClk) disable iff (!system_init_n)
    busy_oe |-> !busy_out && !bus_request_n) else $error("owner not pulling busy low");
  req_pull_a: assert property (@(posedge busClk) disable iff (!system_init_n)
    common_request_oe |-> !common_request_out && !bus_request_n && !busy_oe) else $error("bad request pull");
  init_clear_a: assert property (@(posedge busClk)
    (!system_init_n)[*5] |-> bus_request_n && !busy_oe && !common_request_oe) else $error("init left owner");
  aen_on_a: assert property (@(posedge clk) disable iff (reset)
    $rose(busy_oe) |-> ##[1:12] !address_enable_n) else $error("address enable late");
  aen_off_a: assert property (@(posedge clk) disable iff (reset)
    $fell(busy_oe) |-> ##[1:12] address_enable_n) else $error("address enable stuck");
  lock_keep_a: assert property (@(posedge busClk) disable iff (!system_init_n)
    locked8 ##0 busy_oe |=> busy_oe) else $error("surrendered while locked");
  halt_drop_a: assert property (@(posedge busClk) disable iff (!system_init_n)
    halted[*8] |-> !busy_oe && bus_request_n) else $error("halt kept bus");
  prio_drop_a: assert property (@(posedge busClk) disable iff (!system_init_n)
    (priority_in_n && lock_n)[*8] |-> !busy_oe) else $error("priority ignored");
  cover property (@(posedge busClk) $rose(busy_oe));
  cover property (@(posedge busClk) $rose(common_request_oe));
  cover property (@(posedge busClk) $fell(busy_oe) && priority_in_n);
endmodule // mba_arbiter_props

// ===== verification/mba_bus_model.sv
`timescale 1ns/1ps
module mba_bus_model (
  input wire logic busClk,
  input wire logic otherWants,
  input wire logic higherReq,
  input wire logic priority_out_n,
  input wire logic busy_oe,
  input wire logic busy_out,
  input wire logic common_request_oe,
  input wire logic common_request_out,
  output logic priority_in_n,
  output logic busyWire,
  output logic commonWire
);
  logic otherOwns = 1'h0;
  logic higherSeen = 1'h0;
  // lower-priority board takes a free bus only while this arbiter passes priority on
  always_ff @(posedge busClk) otherOwns <= otherWants && (otherOwns || (busyWire && priority_out_n));
  // higher-priority board changes its request on the bus clock
  always_ff @(posedge busClk) higherSeen <= higherReq;
  assign priority_in_n = higherSeen;
  // pulled-up open-collector wires
  assign busyWire = !((busy_oe && !busy_out) || otherOwns);
  assign commonWire = !((common_request_oe && !common_request_out) || (otherWants && !otherOwns));
endmodule // mba_bus_model

// ===== verification/mba_arbiter_tb.sv
`timescale 1ns/1ps
module mba_arbiter_tb;
  typedef struct {logic [1:0] resp; logic [31:0] mask; logic [31:0] data;} mba_note_t;
  logic clk = 1'h0, busClk = 1'h0, reset = 1'h1, system_init_n = 1'h0, lock_n = 1'h1;
  logic status_bit0_n = 1'h1, status_bit1_n = 1'h1, status_bit2_n = 1'h1, common_req_lockout_n = 1'h0;
  logic resident_mode_strap = 1'h0, io_mode_strap_n = 1'h1, release_on_any_request = 1'h0;
  logic system_or_local_select = 1'h1, priority_in_n, priority_out_n, bus_request_n, busy_in_n, busy_out;
  logic busy_oe, common_request_in_n, common_request_out, common_request_oe, address_enable_n;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'hFFDC;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic other = 1'h0, higher = 1'h0;
  wire [1:0] obs = {address_enable_n, busy_oe};
  int errors = 0, comparisons = 0;
  mba_note_t rq[$], bq[$];
  mba_note_t note;
  always #2.5 clk = ~clk;
  initial begin
    #1.3;
    forever #7.5 busClk = ~busClk;
  end
  mba_arbiter dut (.*);
  mba_bus_model far (.busClk(busClk), .otherWants(other), .higherReq(higher), .priority_out_n(priority_out_n),
    .busy_oe(busy_oe),
    .busy_out(busy_out), .common_request_oe(common_request_oe), .common_request_out(common_request_out),
    .priority_in_n(priority_in_n), .busyWire(busy_in_n), .commonWire(common_request_in_n));
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h got %h", n, e, g);
    end
  endtask
  task test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task tmo(bit b);
    if (b) begin
      errors++;
      test_done();
    end
  endtask
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      note = bq.pop_front();
      check("bresp", note.resp, s_axi_bresp);
    end
    if (s_axi_rvalid && s_axi_rready) begin
      note = rq.pop_front();
      check("rdata", note.data, s_axi_rdata & note.mask);
      check("rresp", note.resp, s_axi_rresp);
    end
  end
  task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] r);
    int k;
    @(posedge clk);
    bq.push_back('{r, 32'h0, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && k < 50);
    s_axi_bready <= 1'h0;
    tmo(k == 50);
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] m, logic [31:0] e, logic [1:0] r);
    int k;
    @(posedge clk);
    rq.push_back('{r, m, e});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && k < 50);
    s_axi_rready <= 1'h0;
    tmo(k == 50);
  endtask
  task automatic waitfor(int i, logic v);
    int k;
    k = 0;
    while (obs[i] !== v && k < 400) begin
      @(posedge clk);
      k++;
    end
    check(i ? "aen" : "owner", v, obs[i]);
    tmo(k == 400);
  endtask
  task automatic hold(int n, logic v);
    repeat (n) @(posedge clk);
    check("owner", v, busy_oe);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    repeat (8) @(posedge clk);
    system_init_n <= 1'h1;
    hold(40, 1'h0);
    check("request", 1'h1, bus_request_n);
    rd(mba_pkg::CTRL_OFFSET, 32'h3, 32'h1, mba_pkg::RESP_OKAY);
    rd(4'h8, 32'hFFFFFFFF, 32'h0, mba_pkg::RESP_SLVERR);
    rnd = xs(rnd);
    wr(mba_pkg::STATUS_OFFSET, rnd, mba_pkg::RESP_OKAY);
    wr(4'h8, rnd, mba_pkg::RESP_SLVERR);
    rnd = xs(rnd);
    wr(mba_pkg::CTRL_OFFSET, {rnd[31:2], 2'h0}, mba_pkg::RESP_OKAY);
    rd(mba_pkg::CTRL_OFFSET, 32'h3, 32'h0, mba_pkg::RESP_OKAY);
    {status_bit2_n, status_bit1_n, status_bit0_n} <= 3'h5;
    hold(60, 1'h0);
    check("request", 1'h1, bus_request_n);
    wr(mba_pkg::CTRL_OFFSET, 32'h1, mba_pkg::RESP_OKAY);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      {io_mode_strap_n, resident_mode_strap} <= {~m[1], m[0]};
      {status_bit2_n, status_bit1_n, status_bit0_n} <= 3'h5;
      system_or_local_select <= 1'h1;
      common_req_lockout_n <= 1'h0;
      waitfor(0, 1'h1);
      waitfor(1, 1'h0);
      rd(mba_pkg::STATUS_OFFSET, 32'h1A, 32'(m * 8 + 2), mba_pkg::RESP_OKAY);
      other <= 1'h1;
      {status_bit2_n, status_bit1_n, status_bit0_n} <= m[0] ? 3'h5 : (m[1] ? 3'h1 : 3'h7);
      system_or_local_select <= ~m[0];
      hold(60, 1'h1);
      common_req_lockout_n <= 1'h1;
      waitfor(0, 1'h0);
      waitfor(1, 1'h1);
      hold(20, 1'h0);
      check("request", 1'h1, bus_request_n);
      other <= 1'h0;
      $display("test mode %0d done", m);
    end
    {io_mode_strap_n, resident_mode_strap, system_or_local_select} <= 3'h5;
    {status_bit2_n, status_bit1_n, status_bit0_n} <= 3'h5;
    waitfor(0, 1'h1);
    lock_n <= 1'h0;
    other <= 1'h1;
    {status_bit2_n, status_bit1_n, status_bit0_n} <= mba_pkg::CODE_HALT;
    hold(60, 1'h1);
    lock_n <= 1'h1;
    waitfor(0, 1'h0);
    hold(20, 1'h0);
    check("request", 1'h1, bus_request_n);
    other <= 1'h0;
    {status_bit2_n, status_bit1_n, status_bit0_n} <= 3'h5;
    waitfor(0, 1'h1);
    $display("test lock done");
    higher <= 1'h1;
    waitfor(0, 1'h0);
    hold(8, 1'h0);
    check("request", 1'h0, bus_request_n);
    check("common", 1'h1, common_request_oe);
    check("priority", 1'h0, priority_out_n);
    rd(mba_pkg::STATUS_OFFSET, 32'h6, 32'h4, mba_pkg::RESP_OKAY);
    higher <= 1'h0;
    waitfor(0, 1'h1);
    $display("test priority done");
    other <= 1'h1;
    hold(60, 1'h1);
    release_on_any_request <= 1'h1;
    waitfor(0, 1'h0);
    other <= 1'h0;
    release_on_any_request <= 1'h0;
    waitfor(0, 1'h1);
    wr(mba_pkg::CTRL_OFFSET, 32'h3, mba_pkg::RESP_OKAY);
    other <= 1'h1;
    waitfor(0, 1'h0);
    wr(mba_pkg::CTRL_OFFSET, 32'h1, mba_pkg::RESP_OKAY);
    other <= 1'h0;
    waitfor(0, 1'h1);
    $display("test any request done");
    system_init_n <= 1'h0;
    hold(16, 1'h0);
    check("request", 1'h1, bus_request_n);
    system_init_n <= 1'h1;
    waitfor(0, 1'h1);
    $display("test init done");
    test_done();
  end
endmodule // mba_arbiter_tb
bind mba_arbiter mba_arbiter_props props (.*);
